// File: design/dhp_pkg.sv
// Constants for the loop holdover history and phase offset block
package dhp_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [11:0] IDX_FREE0    = 12'h400;
  localparam logic [11:0] IDX_FREE1    = 12'h401;
  localparam logic [11:0] IDX_FREE2    = 12'h402;
  localparam logic [11:0] IDX_FREE3    = 12'h403;
  localparam logic [11:0] IDX_HIST_LO  = 12'h40B;
  localparam logic [11:0] IDX_HIST_HI  = 12'h40C;
  localparam logic [11:0] IDX_MODE     = 12'h40D;
  localparam logic [11:0] IDX_FIXED0   = 12'h40E;
  localparam logic [11:0] IDX_FIXED1   = 12'h40F;
  localparam logic [11:0] IDX_FIXED2   = 12'h410;
  localparam logic [11:0] IDX_FIXED3   = 12'h411;
  localparam logic [11:0] IDX_STEP_LO  = 12'h412;
  localparam logic [11:0] IDX_STEP_HI  = 12'h413;
  localparam logic [11:0] IDX_SLEW_LO  = 12'h414;
  localparam logic [11:0] IDX_SLEW_HI  = 12'h415;
  localparam logic [11:0] IDX_CTL      = 12'h420;
  localparam logic [11:0] IDX_HOLD_WD  = 12'h421;
  localparam logic [11:0] IDX_STATUS   = 12'h422;
  localparam logic [11:0] IDX_ACCUM    = 12'h423;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] HIST_TIMER_RST = 16'h000A;
  localparam logic [4:0]  MODE_RST       = 5'h00;
  localparam logic [29:0] FIXED_RST      = 30'h0000_0000;
  localparam logic [15:0] STEP_RST       = 16'h0000;
  localparam logic [29:0] FREE_RST       = 30'h0000_0000;
  localparam logic [15:0] SLEW_RST       = 16'h0000;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MODE_INCR_LSB     = 0;
  localparam int MODE_PERSIST_BIT  = 3;
  localparam int MODE_FALLBACK_BIT = 4;
  localparam int CTL_INC_BIT       = 0;
  localparam int CTL_DEC_BIT       = 1;
  localparam int CTL_CLR_BIT       = 2;
  localparam int STAT_VALID_BIT    = 0;
  localparam int STAT_FIRST_BIT    = 1;

  // ------------------------------------------------------------
  // Incremental averaging codes
  // ------------------------------------------------------------
  localparam logic [2:0] INCR_ALL_CODE   = 3'h7;
  localparam int         INCR_ALL_POINTS = 8;

  // ------------------------------------------------------------
  // Timing: one history tick is one millisecond
  // ------------------------------------------------------------
  localparam int MS_NS         = 1000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

endpackage : dhp_pkg

// File: design/dhp_avg_div.sv
// Serial restoring divider forming the averaged tuning word
`timescale 1ns/100ps
module dhp_avg_div #(
  parameter int DW = 46,
  parameter int VW = 16,
  parameter int QW = 30
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Request
  input  wire logic          start,
  input  wire logic [DW-1:0] dividend,
  input  wire logic [VW-1:0] divisor,
  // Answer
  output logic               busy,
  output logic               done,
  output logic [QW-1:0]      quot
);

  if (QW > DW || VW < 1 || DW > 127) begin : g_bad_width
    $error("dhp_avg_div: widths cannot be served");
  end

  typedef enum logic {DIV_IDLE, DIV_RUN} dhp_div_state_type;

  typedef struct packed {
    dhp_div_state_type     st;
    logic [6:0]            cnt;
    logic [VW-1:0]         div;
    logic [VW-1:0]         rem;
    logic [DW-1:0]         num;
    logic                  done;
  } dhp_div_type;

  dhp_div_type s_r;
  dhp_div_type s_nxt;
  logic [VW:0] trial;

  // ------------------------------------------------------------
  // One quotient bit per cycle
  // ------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    trial      = {s_r.rem, s_r.num[DW-1]};
    case (s_r.st)
      DIV_IDLE: begin
        if (start) begin
          s_nxt.st  = DIV_RUN;
          s_nxt.cnt = 7'(DW);
          s_nxt.div = divisor;
          s_nxt.rem = '0;
          s_nxt.num = dividend;
        end
      end
      DIV_RUN: begin
        if (trial >= {1'b0, s_r.div}) begin
          s_nxt.rem = VW'(trial - {1'b0, s_r.div});
          s_nxt.num = {s_r.num[DW-2:0], 1'b1};
        end else begin
          s_nxt.rem = trial[VW-1:0];
          s_nxt.num = {s_r.num[DW-2:0], 1'b0};
        end
        s_nxt.cnt = s_r.cnt - 7'h01;
        if (s_r.cnt == 7'h01) begin
          s_nxt.st   = DIV_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.st = DIV_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: DIV_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = (s_r.st == DIV_RUN);
  assign done = s_r.done;
  assign quot = s_r.num[QW-1:0];

endmodule : dhp_avg_div

// File: design/dhp_core.sv
// Holdover history averaging and closed-loop phase offset for one loop
// How it works
// - Interval is 16-bit milliseconds, reset 10 ms
// - Average tuning word becomes holdover word
// - No history: fallback bit picks free/last word
// - Reference switch clears history unless persistent
// - Nonzero incremental field gives early updates
// - After first interval, update only at ends
// - Incremental zero: no early update at all
// - Codes 1-3 add half, quarter, eighth points
// - Code 7 gives eight points down to 1/256
// - Signed 30-bit fixed offset, four bytes LSB-first
// - 16-bit step size for locked offset moves
// - Increment, decrement, clear move accumulated offset
// - Free-running word is 30 bits in four bytes
// - Offset changes slewed; zero limit disables slewing
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module dhp_core #(
  parameter int CYCLES_PER_MS = dhp_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Loop side
  input  wire logic [29:0] loop_tw,
  input  wire logic        loop_locked,
  input  wire logic        holdover,
  input  wire logic        ref_switch,
  // Results
  output logic [29:0]      holdover_tw,
  output logic             history_valid,
  output logic [31:0]      phase_offset
);

  if (CYCLES_PER_MS < 64) begin : g_bad_ms
    $error("dhp_core: CYCLES_PER_MS too small for the divider");
  end

  localparam int CW = $clog2(CYCLES_PER_MS);

  typedef struct packed {
    logic [CW-1:0] tick;
    logic [15:0]   timer;
    logic [4:0]    mode;
    logic [29:0]   fixed;
    logic [15:0]   step;
    logic [29:0]   free;
    logic [15:0]   slew;
    logic [31:0]   prdata;
    logic          perr;
    logic [15:0]   elapsed;
    logic [45:0]   sum;
    logic [15:0]   cnt;
    logic          first_done;
    logic          hist_valid;
    logic [29:0]   hist_word;
    logic [29:0]   last_tw;
    logic [29:0]   hold_word;
    logic [31:0]   accum;
    logic [31:0]   applied;
    logic          div_go;
    logic [45:0]   div_a;
    logic [15:0]   div_b;
  } dhp_core_type;

  dhp_core_type s_r;
  dhp_core_type s_nxt;

  logic        div_busy;
  logic        div_done;
  logic [29:0] div_quot;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Early update point of the first interval
  function automatic logic early_hit(input logic [15:0] el, input logic [15:0] tm,
                                     input logic [2:0] code);
    int   n;
    logic hit;
    n   = (code == dhp_pkg::INCR_ALL_CODE) ? dhp_pkg::INCR_ALL_POINTS : int'(code);
    hit = 1'b0;
    for (int k = 1; k <= dhp_pkg::INCR_ALL_POINTS; k++) begin
      if (k <= n && (tm >> k) != 16'h0000 && el == (tm >> k)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : early_hit

  // True for a word address that maps to a register, else false
  function automatic logic addr_ok(input logic [15:0] a);
    logic [11:0] i;
    i = a[13:2];
    return a[1:0] == 2'b00 && a[15:14] == 2'b00 &&
           ((i >= dhp_pkg::IDX_FREE0 && i <= dhp_pkg::IDX_FREE3) ||
            (i >= dhp_pkg::IDX_HIST_LO && i <= dhp_pkg::IDX_SLEW_HI) ||
            (i >= dhp_pkg::IDX_CTL && i <= dhp_pkg::IDX_ACCUM));
  endfunction : addr_ok

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic        tick_now;
    logic        wr;
    logic [11:0] idx;
    logic [7:0]  wb;
    logic [45:0] sum_n;
    logic [15:0] cnt_n;
    logic [15:0] el_n;
    logic [31:0] target;
    logic [32:0] diff;
    logic        inc;
    logic        dec;
    logic        clr;
    tick_now = (s_r.tick == CW'(CYCLES_PER_MS - 1));
    wr       = psel && penable && pwrite && addr_ok(paddr);
    idx      = paddr[13:2];
    wb       = pwdata[7:0];
    sum_n    = s_r.sum + {16'h0000, loop_tw};
    cnt_n    = s_r.cnt + 16'h0001;
    el_n     = s_r.elapsed + 16'h0001;
    inc      = 1'b0;
    dec      = 1'b0;
    clr      = 1'b0;
    target   = {{2{s_r.fixed[29]}}, s_r.fixed} + s_r.accum;
    diff     = {target[31], target} - {s_r.applied[31], s_r.applied};
    s_nxt         = s_r;
    s_nxt.div_go  = 1'b0;
    s_nxt.last_tw = loop_tw;
    // Millisecond timebase
    s_nxt.tick = tick_now ? '0 : s_r.tick + CW'(1);

    // Register writes; reserved bits are dropped
    if (wr) begin
      if (idx == dhp_pkg::IDX_FREE0) begin
        s_nxt.free[7:0] = wb;
      end else if (idx == dhp_pkg::IDX_FREE1) begin
        s_nxt.free[15:8] = wb;
      end else if (idx == dhp_pkg::IDX_FREE2) begin
        s_nxt.free[23:16] = wb;
      end else if (idx == dhp_pkg::IDX_FREE3) begin
        s_nxt.free[29:24] = wb[5:0];
      end else if (idx == dhp_pkg::IDX_HIST_LO) begin
        s_nxt.timer[7:0] = wb;
      end else if (idx == dhp_pkg::IDX_HIST_HI) begin
        s_nxt.timer[15:8] = wb;
      end else if (idx == dhp_pkg::IDX_MODE) begin
        s_nxt.mode = wb[4:0];
      end else if (idx == dhp_pkg::IDX_FIXED0) begin
        s_nxt.fixed[7:0] = wb;
      end else if (idx == dhp_pkg::IDX_FIXED1) begin
        s_nxt.fixed[15:8] = wb;
      end else if (idx == dhp_pkg::IDX_FIXED2) begin
        s_nxt.fixed[23:16] = wb;
      end else if (idx == dhp_pkg::IDX_FIXED3) begin
        s_nxt.fixed[29:24] = wb[5:0];
      end else if (idx == dhp_pkg::IDX_STEP_LO) begin
        s_nxt.step[7:0] = wb;
      end else if (idx == dhp_pkg::IDX_STEP_HI) begin
        s_nxt.step[15:8] = wb;
      end else if (idx == dhp_pkg::IDX_SLEW_LO) begin
        s_nxt.slew[7:0] = wb;
      end else if (idx == dhp_pkg::IDX_SLEW_HI) begin
        s_nxt.slew[15:8] = wb;
      end else if (idx == dhp_pkg::IDX_CTL) begin
        inc = wb[dhp_pkg::CTL_INC_BIT];
        dec = wb[dhp_pkg::CTL_DEC_BIT];
        clr = wb[dhp_pkg::CTL_CLR_BIT];
      end
    end

    // Read data captured in the setup cycle
    if (psel && !penable) begin
      s_nxt.perr   = !addr_ok(paddr);
      s_nxt.prdata = 32'h0000_0000;
      if (idx == dhp_pkg::IDX_FREE0) begin
        s_nxt.prdata[7:0] = s_r.free[7:0];
      end else if (idx == dhp_pkg::IDX_FREE1) begin
        s_nxt.prdata[7:0] = s_r.free[15:8];
      end else if (idx == dhp_pkg::IDX_FREE2) begin
        s_nxt.prdata[7:0] = s_r.free[23:16];
      end else if (idx == dhp_pkg::IDX_FREE3) begin
        s_nxt.prdata[5:0] = s_r.free[29:24];
      end else if (idx == dhp_pkg::IDX_HIST_LO) begin
        s_nxt.prdata[7:0] = s_r.timer[7:0];
      end else if (idx == dhp_pkg::IDX_HIST_HI) begin
        s_nxt.prdata[7:0] = s_r.timer[15:8];
      end else if (idx == dhp_pkg::IDX_MODE) begin
        s_nxt.prdata[4:0] = s_r.mode;
      end else if (idx == dhp_pkg::IDX_FIXED0) begin
        s_nxt.prdata[7:0] = s_r.fixed[7:0];
      end else if (idx == dhp_pkg::IDX_FIXED1) begin
        s_nxt.prdata[7:0] = s_r.fixed[15:8];
      end else if (idx == dhp_pkg::IDX_FIXED2) begin
        s_nxt.prdata[7:0] = s_r.fixed[23:16];
      end else if (idx == dhp_pkg::IDX_FIXED3) begin
        s_nxt.prdata[5:0] = s_r.fixed[29:24];
      end else if (idx == dhp_pkg::IDX_STEP_LO) begin
        s_nxt.prdata[7:0] = s_r.step[7:0];
      end else if (idx == dhp_pkg::IDX_STEP_HI) begin
        s_nxt.prdata[7:0] = s_r.step[15:8];
      end else if (idx == dhp_pkg::IDX_SLEW_LO) begin
        s_nxt.prdata[7:0] = s_r.slew[7:0];
      end else if (idx == dhp_pkg::IDX_SLEW_HI) begin
        s_nxt.prdata[7:0] = s_r.slew[15:8];
      end else if (idx == dhp_pkg::IDX_HOLD_WD) begin
        s_nxt.prdata[29:0] = s_r.hold_word;
      end else if (idx == dhp_pkg::IDX_STATUS) begin
        s_nxt.prdata[dhp_pkg::STAT_VALID_BIT] = s_r.hist_valid;
        s_nxt.prdata[dhp_pkg::STAT_FIRST_BIT] = s_r.first_done;
      end else if (idx == dhp_pkg::IDX_ACCUM) begin
        s_nxt.prdata = s_r.accum;
      end
    end

    // Accumulate one sample per millisecond outside holdover
    if (tick_now && !holdover) begin
      s_nxt.sum     = sum_n;
      s_nxt.cnt     = cnt_n;
      s_nxt.elapsed = el_n;
      if (el_n >= s_r.timer) begin
        // Full interval: publish and restart
        s_nxt.div_go     = 1'b1;
        s_nxt.div_a      = sum_n;
        s_nxt.div_b      = cnt_n;
        s_nxt.sum        = '0;
        s_nxt.cnt        = '0;
        s_nxt.elapsed    = '0;
        s_nxt.first_done = 1'b1;
      end else if (!s_r.first_done &&
                   early_hit(el_n, s_r.timer, s_r.mode[2:0])) begin
        // Early point within the first interval only
        s_nxt.div_go = 1'b1;
        s_nxt.div_a  = sum_n;
        s_nxt.div_b  = cnt_n;
      end
    end
    // Average becomes the history word
    if (div_done) begin
      s_nxt.hist_word  = div_quot;
      s_nxt.hist_valid = 1'b1;
    end
    // New reference: erase history unless persistent
    if (ref_switch && !s_r.mode[dhp_pkg::MODE_PERSIST_BIT]) begin
      s_nxt.sum        = '0;
      s_nxt.cnt        = '0;
      s_nxt.elapsed    = '0;
      s_nxt.first_done = 1'b0;
      s_nxt.hist_valid = 1'b0;
    end
    // Holdover word tracks until holdover, then stays frozen
    if (!holdover) begin
      if (s_r.hist_valid) begin
        s_nxt.hold_word = s_r.hist_word;
      end else if (s_r.mode[dhp_pkg::MODE_FALLBACK_BIT]) begin
        s_nxt.hold_word = s_r.last_tw;
      end else begin
        s_nxt.hold_word = s_r.free;
      end
    end

    // Accumulated offset moves by one step while locked
    if (clr) begin
      s_nxt.accum = 32'h0000_0000;
    end else if (inc && loop_locked) begin
      s_nxt.accum = s_r.accum + {16'h0000, s_r.step};
    end else if (dec && loop_locked) begin
      s_nxt.accum = s_r.accum - {16'h0000, s_r.step};
    end
    // Applied offset slews to target at limit ps per ms
    if (s_r.slew == 16'h0000) begin
      s_nxt.applied = target;
    end else if (tick_now) begin
      if (!diff[32] && diff > {17'h00000, s_r.slew}) begin
        s_nxt.applied = s_r.applied + {16'h0000, s_r.slew};
      end else if (diff[32] && (-diff) > {17'h00000, s_r.slew}) begin
        s_nxt.applied = s_r.applied - {16'h0000, s_r.slew};
      end else begin
        s_nxt.applied = target;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r       <= '0;
      s_r.timer <= dhp_pkg::HIST_TIMER_RST;
      s_r.mode  <= dhp_pkg::MODE_RST;
      s_r.fixed <= dhp_pkg::FIXED_RST;
      s_r.step  <= dhp_pkg::STEP_RST;
      s_r.free  <= dhp_pkg::FREE_RST;
      s_r.slew  <= dhp_pkg::SLEW_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Average of the sampled words
  dhp_avg_div #(.DW(46), .VW(16), .QW(30)) u_div (
    .clk      (clk),
    .rst      (rst),
    .start    (s_r.div_go),
    .dividend (s_r.div_a),
    .divisor  (s_r.div_b),
    .busy     (div_busy),
    .done     (div_done),
    .quot     (div_quot)
  );

  // Outputs
  assign pready        = 1'b1;
  assign prdata        = s_r.prdata;
  assign pslverr       = s_r.perr;
  assign holdover_tw   = s_r.hold_word;
  assign history_valid = s_r.hist_valid;
  assign phase_offset  = s_r.applied;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_DIV_FINISH: assert property (s_r.div_go |-> ##[47:48] div_done)
    else $error("average not ready in time");
  AST_FULL_UPDATE: assert property (
    s_r.div_go && s_r.first_done |-> s_r.elapsed == 16'h0000)
    else $error("update inside an interval after the first");
  AST_NO_EARLY: assert property (
    s_r.div_go && s_r.mode[2:0] == 3'h0 |-> s_r.elapsed == 16'h0000)
    else $error("early update with incremental field zero");
  AST_FALLBACK_FREE: assert property (
    !holdover && !s_r.hist_valid && !s_r.mode[dhp_pkg::MODE_FALLBACK_BIT]
    |=> holdover_tw == $past(s_r.free))
    else $error("fallback did not use free-running word");
  AST_FALLBACK_LAST: assert property (
    !holdover && !s_r.hist_valid && s_r.mode[dhp_pkg::MODE_FALLBACK_BIT]
    |=> holdover_tw == $past(loop_tw, 2))
    else $error("fallback did not use last loop word");
  AST_SWITCH_CLEAR: assert property (
    ref_switch && !s_r.mode[dhp_pkg::MODE_PERSIST_BIT]
    |=> !history_valid ##1 (!history_valid || $past(div_done)))
    else $error("history survived a reference switch");
  AST_SWITCH_KEEP: assert property (
    ref_switch && s_r.mode[dhp_pkg::MODE_PERSIST_BIT] && history_valid |=> history_valid)
    else $error("persistent history was lost");
  AST_HOLD_FROZEN: assert property (
    holdover && $past(holdover) |-> $stable(holdover_tw))
    else $error("holdover word moved during holdover");
  AST_SLEW_OFF: assert property (
    s_r.slew == 16'h0000 && $stable(s_r.slew) && $stable(s_r.fixed) && $stable(s_r.accum)
    |-> phase_offset == {{2{s_r.fixed[29]}}, s_r.fixed} + s_r.accum)
    else $error("offset not applied at once with slewing off");
  AST_RSVD_ZERO: assert property (
    psel && !penable && paddr[13:2] == dhp_pkg::IDX_MODE |=> prdata[31:5] == 27'h0)
    else $error("reserved mode bits read nonzero");

  COV_EARLY_ALL: cover property (s_r.div_go && !s_r.first_done && s_r.mode[2:0] == 3'h7);
  COV_FULL: cover property (s_r.div_go && s_r.elapsed == 16'h0000 ##[1:60] history_valid);
  COV_HOLD_HIST: cover property (history_valid ##1 holdover);
  COV_SLEWING: cover property (s_r.slew != 16'h0000 && phase_offset != 32'h0 ##1
                               $changed(phase_offset));

endmodule : dhp_core

// File: tb/testbench.sv
// Self-checking bench for the holdover history and phase offset block
`timescale 1ns/100ps
module testbench;
  // ------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------
  localparam int TPM = 64;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, phase_offset, rd, pexp;
  logic [29:0] loop_tw, holdover_tw, v, f;
  logic        loop_locked, holdover, ref_switch, history_valid, err;
  logic [15:0] s;
  int          errors, checks, seed, e, n;
  int          modes[5] = '{0, 1, 2, 3, 7};

  dhp_core #(.CYCLES_PER_MS(TPM)) u_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .loop_tw(loop_tw), .loop_locked(loop_locked),
    .holdover(holdover), .ref_switch(ref_switch), .holdover_tw(holdover_tw),
    .history_valid(history_valid), .phase_offset(phase_offset));

  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Tasks and functions
  // ------------------------------------------------------------
  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) errors++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read a register and compare it
  task automatic rc(input string nm, input logic [11:0] idx, input logic [31:0] ex);
    apb(1'b0, idx, 32'h0);
    chk(nm, ex, rd);
    chk("rd_err", 32'h0, {31'h0, err});
    chk("pready", 32'h1, {31'h0, pready});
  endtask : rc

  // One-cycle reference switch pulse
  task automatic pulse_switch();
    @(posedge clk);
    ref_switch <= 1'b1;
    @(posedge clk);
    ref_switch <= 1'b0;
  endtask : pulse_switch

  // First history update point, in ms, for a mode and timer
  function automatic int first_pt(input int m, input int t);
    int p;
    p = t;
    for (int k = 1; k <= ((m == 7) ? 8 : m); k++) begin
      if ((t >> k) != 0) p = t >> k;
    end
    return p;
  endfunction : first_pt

  // Verdict and end of run
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    errors = 0; checks = 0; seed = 4702;
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000;
    pwdata = 32'h0; loop_tw = 30'h0; loop_locked = 1'b0; holdover = 1'b0;
    ref_switch = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values and reserved bits
    rc("timer_lo", dhp_pkg::IDX_HIST_LO, 32'h0A);
    rc("timer_hi", dhp_pkg::IDX_HIST_HI, 32'h00);
    rc("mode", dhp_pkg::IDX_MODE, 32'h00);
    apb(1'b1, dhp_pkg::IDX_MODE, 32'hFF);
    rc("mode_rsvd", dhp_pkg::IDX_MODE, 32'h1F);
    for (logic [11:0] i = dhp_pkg::IDX_FIXED0; i <= dhp_pkg::IDX_STEP_HI; i++) begin
      rc("byte_rst", i, 32'h00);
      pexp = 32'($random(seed)) & 32'hFF;
      apb(1'b1, i, pexp);
      rc("byte_rw", i, (i == dhp_pkg::IDX_FIXED3) ? (pexp & 32'h3F) : pexp);
    end
    apb(1'b0, 12'h500, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    // Fixed offset plus locked increments
    f = 30'($random(seed));
    s = 16'($random(seed));
    for (int b = 0; b < 4; b++) apb(1'b1, dhp_pkg::IDX_FIXED0 + 12'(b), 32'(f >> (8 * b)) & 32'hFF);
    apb(1'b1, dhp_pkg::IDX_STEP_LO, {24'h0, s[7:0]});
    apb(1'b1, dhp_pkg::IDX_STEP_HI, {24'h0, s[15:8]});
    pexp = {{2{f[29]}}, f};
    repeat (3) @(posedge clk);
    chk("offset_fixed", pexp, phase_offset);
    loop_locked <= 1'b1;
    apb(1'b1, dhp_pkg::IDX_CTL, 32'h1);
    repeat (3) @(posedge clk);
    chk("offset_inc", pexp + {16'h0, s}, phase_offset);
    rc("accum", dhp_pkg::IDX_ACCUM, {16'h0, s});
    apb(1'b1, dhp_pkg::IDX_CTL, 32'h2);
    apb(1'b1, dhp_pkg::IDX_CTL, 32'h2);
    repeat (3) @(posedge clk);
    chk("offset_dec", pexp - {16'h0, s}, phase_offset);
    apb(1'b1, dhp_pkg::IDX_CTL, 32'h4);
    loop_locked <= 1'b0;
    apb(1'b1, dhp_pkg::IDX_CTL, 32'h1);
    repeat (3) @(posedge clk);
    chk("offset_clr", pexp, phase_offset);
    // Slewed move: step 2 at limit 1 ps per ms
    loop_locked <= 1'b1;
    apb(1'b1, dhp_pkg::IDX_SLEW_LO, 32'h1);
    apb(1'b1, dhp_pkg::IDX_STEP_LO, 32'h2);
    apb(1'b1, dhp_pkg::IDX_STEP_HI, 32'h0);
    apb(1'b1, dhp_pkg::IDX_CTL, 32'h1);
    n = 0;
    while (phase_offset === pexp && n < 2 * TPM) begin
      @(posedge clk);
      n++;
    end
    chk("slew_first", pexp + 32'h1, phase_offset);
    repeat (TPM + 8) @(posedge clk);
    chk("slew_done", pexp + 32'h2, phase_offset);
    apb(1'b1, dhp_pkg::IDX_SLEW_LO, 32'h0);
    apb(1'b1, dhp_pkg::IDX_CTL, 32'h4);
    loop_locked <= 1'b0;
    // History updates per incremental mode; interval never zero
    apb(1'b1, dhp_pkg::IDX_HIST_LO, 32'h20);
    apb(1'b1, dhp_pkg::IDX_MODE, 32'h0);
    pulse_switch();
    repeat (60) @(posedge clk);
    foreach (modes[j]) begin
      v = 30'($random(seed));
      loop_tw <= v;
      apb(1'b1, dhp_pkg::IDX_MODE, 32'(modes[j]));
      pulse_switch();
      e = first_pt(modes[j], 32);
      repeat ((e - 1) * TPM + 40) @(posedge clk);
      chk("early_quiet", 32'h0, {31'h0, history_valid});
      n = 0;
      while (history_valid !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      chk("update_valid", 32'h1, {31'h0, history_valid});
      repeat (2) @(posedge clk);
      chk("avg_word", {2'h0, v}, {2'h0, holdover_tw});
    end
    // Persistent history survives a switch
    apb(1'b1, dhp_pkg::IDX_MODE, 32'h08);
    pulse_switch();
    repeat (3) @(posedge clk);
    chk("persist", 32'h1, {31'h0, history_valid});
    // Fallback words with no history
    f = 30'($random(seed));
    for (int b = 0; b < 4; b++) apb(1'b1, dhp_pkg::IDX_FREE0 + 12'(b), 32'(f >> (8 * b)) & 32'hFF);
    for (int fb = 0; fb < 2; fb++) begin
      apb(1'b1, dhp_pkg::IDX_MODE, fb ? 32'h10 : 32'h00);
      pulse_switch();
      repeat (2) @(posedge clk);
      chk("cleared", 32'h0, {31'h0, history_valid});
      holdover <= 1'b1;
      repeat (3) @(posedge clk);
      chk("fallback", {2'h0, fb ? v : f}, {2'h0, holdover_tw});
      holdover <= 1'b0;
    end
    end_of_test();
  end
endmodule : testbench
